// ---- shared/acdp_pkg.sv ----
// Constants and carrier types shared by the auxiliary control block.
`default_nettype none
package acdp_pkg;
    // Bus geometry and register indices; byte address is four times index.
    localparam int ADDR_W = 12;
    localparam logic [11:0] AUX_IDX = 12'h0a2;
    localparam logic [11:0] STAT_IDX = 12'h0a3;
    localparam logic [11:0] MASK_IDX = 12'h0a4;
    // Field positions inside the auxiliary control byte.
    localparam int BIT_PSEL = 0;
    localparam int BIT_RSVD = 1;
    localparam int BIT_ZERO = 2;
    localparam int BIT_SOFT_RESET_BIT = 3;
    localparam int BIT_LPNVM = 4;
    localparam int BIT_BOI = 5;
    localparam int BIT_BOD = 6;
    localparam int BIT_KPF = 7;
    // Interrupt status and mask layout.
    localparam int IRQ_W = 2;
    localparam int IRQ_KEYPAD = 0;
    localparam int IRQ_BROWNOUT = 1;
    // Reset values.
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] RESTART_ADDR = 16'h0000;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing: chip reset is stretched to at least this long.
    localparam int CLK_PERIOD_NS = 5;
    localparam int RST_HOLD_NS = 20;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

    typedef enum logic [1:0] {REG_AUX, REG_STAT, REG_MASK, REG_NONE} acdp_reg_e;

    // One pointer operation from the instruction decoder per cycle.
    typedef struct packed {
        logic load;
        logic inc;
        logic wrHigh;
        logic wrLow;
        logic dataMove;
        logic [15:0] data;
    } acdp_ptr_op_s;

    typedef struct packed {
        logic keypadFlag;
        logic brownoutDisable;
        logic brownoutIrqSel;
        logic lowPowerNvm;
        logic pointerSelect;
    } acdp_aux_s;

    typedef struct packed {
        acdp_aux_s aux;
        logic [IRQ_W-1:0] stat;
        logic [IRQ_W-1:0] mask;
        logic awHave;
        logic wHave;
        logic [ADDR_W-1:0] awAddr;
        logic [31:0] wData;
        logic wStrb0;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic softRst;
        logic nvmReq;
        logic [15:0] nvmAddr;
    } acdp_main_s;

    typedef struct packed {
        logic [1:0][15:0] ptr;
    } acdp_ptr_s;

    typedef struct packed {
        logic active;
        logic [7:0] cnt;
    } acdp_rst_s;

    function automatic acdp_reg_e acdp_decode(input logic [ADDR_W-1:0] a);
        acdp_reg_e r;
        r = REG_NONE;
        if (a[1:0] == 2'h0) begin
            if (a[11:2] == AUX_IDX[9:0]) r = REG_AUX;
            else if (a[11:2] == STAT_IDX[9:0]) r = REG_STAT;
            else if (a[11:2] == MASK_IDX[9:0]) r = REG_MASK;
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// ---- hw/acdp_dual_pointer.sv ----
// Two independent 16-bit data pointers with one of them selected.
`timescale 1ns/1ps
`default_nettype none
module acdp_dual_pointer (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chipReset,
    input wire logic ce,
    // Selection and operation
    input wire logic pointerSelect,
    input wire acdp_pkg::acdp_ptr_op_s ptrOp,
    // Selected pointer value
    output logic [15:0] selPointer
);
    import acdp_pkg::*;

    acdp_ptr_s q, d;

    always_comb begin
        d = q;
        // Only the selected pointer is touched; the other keeps its value.
        if (ptrOp.load) begin
            d.ptr[pointerSelect] = ptrOp.data;
        end else if (ptrOp.inc) begin
            d.ptr[pointerSelect] = q.ptr[pointerSelect] + 16'h0001;
        end else begin
            if (ptrOp.wrHigh) d.ptr[pointerSelect][15:8] = ptrOp.data[7:0];
            if (ptrOp.wrLow) d.ptr[pointerSelect][7:0] = ptrOp.data[7:0];
        end
        if (chipReset) begin
            d.ptr[0] = PTR_RESET;
            d.ptr[1] = PTR_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q.ptr[0] <= PTR_RESET;
            q.ptr[1] <= PTR_RESET;
        end else if (ce) begin
            q <= d;
        end
    end

    // Byte reads and jumps see the selected pointer only.
    assign selPointer = q.ptr[pointerSelect];

    property p_inc_sel;
        @(posedge clk) disable iff (sys_rst || chipReset)
        ce && ptrOp.inc && !ptrOp.load
        |=> q.ptr[$past(pointerSelect)] == $past(selPointer) + 16'h0001;
    endproperty
    a_inc_sel: assert property (p_inc_sel) else $error("pointer increment wrong");

    property p_other_kept;
        @(posedge clk) disable iff (sys_rst || chipReset)
        1'b1 |=> q.ptr[!$past(pointerSelect)] == $past(q.ptr[!pointerSelect]);
    endproperty
    a_other_kept: assert property (p_other_kept) else $error("unselected pointer changed");

    property p_load_sel;
        @(posedge clk) disable iff (sys_rst || chipReset)
        ce && ptrOp.load ##1 pointerSelect == $past(pointerSelect)
        |-> selPointer == $past(ptrOp.data);
    endproperty
    a_load_sel: assert property (p_load_sel) else $error("pointer load lost");
endmodule
`default_nettype wire

// ---- hw/acdp_reset_gen.sv ----
// Chip reset generator merging soft, external, watchdog and brownout requests.
`timescale 1ns/1ps
`default_nettype none
module acdp_reset_gen #(
    parameter int HOLD = acdp_pkg::RST_HOLD_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Reset sources
    input wire logic softReq,
    input wire logic extReq,
    input wire logic wdogReq,
    input wire logic bodReq,
    // Chip reset level
    output logic chipReset
);
    import acdp_pkg::*;

    acdp_rst_s q, d;
    logic anyReq;

    // All sources share one path so a soft reset is indistinguishable.
    assign anyReq = softReq | extReq | wdogReq | bodReq;

    always_comb begin
        d = q;
        d.active = anyReq | (q.cnt != 8'h00);
        if (anyReq) d.cnt = 8'(HOLD - 1);
        else if (q.cnt != 8'h00) d.cnt = q.cnt - 8'h01;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign chipReset = q.active;

    property p_same_effect;
        @(posedge clk) disable iff (sys_rst || !ce)
        (softReq || extReq || wdogReq) |=> chipReset;
    endproperty
    a_same_effect: assert property (p_same_effect) else $error("reset source ignored");
endmodule
`default_nettype wire

// ---- hw/acdp_aux_control.sv ----
// Auxiliary control register with dual pointer select and AXI4-Lite access.
`timescale 1ns/1ps
`default_nettype none
module acdp_aux_control #(
    parameter int RST_HOLD = acdp_pkg::RST_HOLD_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [acdp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [acdp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Instruction decoder side
    input wire acdp_pkg::acdp_ptr_op_s ptrOp,
    output logic [15:0] selPointer,
    output logic nvmCfgReq,
    output logic [15:0] nvmCfgAddr,
    // Events and reset sources
    input wire logic keypadEvent,
    input wire logic brownoutEvent,
    input wire logic extResetReq,
    input wire logic watchdogReq,
    // Chip control
    output logic chipReset,
    output logic [15:0] restartAddr,
    output logic brownoutDetectOff,
    output logic lowPowerNvm,
    output logic irq
);
    import acdp_pkg::*;

    acdp_main_s q, d;
    logic doWrite;
    acdp_reg_e wSel;
    acdp_reg_e rSel;
    logic [7:0] auxRead;
    logic bodReset;

    function automatic logic [7:0] pack_aux(input acdp_aux_s a);
        logic [7:0] v;
        v = AUX_RESET;
        v[BIT_KPF] = a.keypadFlag;
        v[BIT_BOD] = a.brownoutDisable;
        v[BIT_BOI] = a.brownoutIrqSel;
        v[BIT_LPNVM] = a.lowPowerNvm;
        v[BIT_PSEL] = a.pointerSelect;
        return v;
    endfunction

    // Soft reset and zero bits never hold state, so they read as zero.
    assign auxRead = pack_aux(q.aux);
    assign doWrite = q.awHave & q.wHave & ~q.bValid;
    assign wSel = acdp_decode(q.awAddr);
    assign rSel = acdp_decode(s_axi_araddr);
    // A detected brownout resets the chip unless detection is disabled or it is rerouted as interrupt.
    assign bodReset = brownoutEvent & ~q.aux.brownoutIrqSel
                      & ~q.aux.brownoutDisable;

    always_comb begin
        d = q;
        d.softRst = 1'b0;
        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            d.awHave = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.wHave = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb0 = s_axi_wstrb[0];
        end
        if (doWrite) begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.bValid = 1'b1;
            d.bResp = (wSel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (q.wStrb0) begin
                unique case (wSel)
                    REG_AUX: begin
                        // Bits one and two are not stored, so an increment
                        // only flips the select bit.
                        d.aux.pointerSelect = q.wData[BIT_PSEL];
                        d.aux.keypadFlag = q.aux.keypadFlag
                                           & q.wData[BIT_KPF];
                        d.aux.brownoutDisable = q.wData[BIT_BOD];
                        d.aux.brownoutIrqSel = q.wData[BIT_BOI];
                        d.aux.lowPowerNvm = q.wData[BIT_LPNVM];
                        d.softRst = q.wData[BIT_SOFT_RESET_BIT];
                    end
                    REG_STAT: d.stat = q.stat & ~q.wData[IRQ_W-1:0];
                    REG_MASK: d.mask = q.wData[IRQ_W-1:0];
                    REG_NONE: d.mask = q.mask;
                endcase
            end
        end
        if (s_axi_bvalid && s_axi_bready) d.bValid = 1'b0;
        // Read channel: one read in flight, answered the next cycle.
        if (s_axi_arvalid && s_axi_arready) begin
            d.rValid = 1'b1;
            d.rResp = RESP_OKAY;
            unique case (rSel)
                REG_AUX: d.rData = {24'h00_0000, auxRead};
                REG_STAT: d.rData = {30'h0000_0000, q.stat};
                REG_MASK: d.rData = {30'h0000_0000, q.mask};
                REG_NONE: begin
                    d.rData = 32'h0000_0000;
                    d.rResp = RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            d.rValid = 1'b0;
        end
        // Hardware sets are applied after software clears so a
        // coinciding event is never lost.
        if (keypadEvent) begin
            d.aux.keypadFlag = 1'b1;
            d.stat[IRQ_KEYPAD] = 1'b1;
        end
        if (brownoutEvent && q.aux.brownoutIrqSel && !q.aux.brownoutDisable) begin
            d.stat[IRQ_BROWNOUT] = 1'b1;
        end
        // Data moves address the configuration space via the pointer.
        d.nvmReq = ptrOp.dataMove;
        d.nvmAddr = selPointer;
        // Chip reset returns every register to its initial value; the bus
        // handshake state survives so a pending response is not dropped.
        if (chipReset) begin
            d.aux = '0;
            d.stat = IRQ_RESET;
            d.mask = IRQ_RESET;
            d.softRst = 1'b0;
            d.nvmReq = 1'b0;
            d.nvmAddr = PTR_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    acdp_dual_pointer u_ptr (
        .clk(clk),
        .sys_rst(sys_rst),
        .chipReset(chipReset),
        .ce(ce),
        .pointerSelect(q.aux.pointerSelect),
        .ptrOp(ptrOp),
        .selPointer(selPointer)
    );

    acdp_reset_gen #(
        .HOLD(RST_HOLD)
    ) u_rst (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .softReq(q.softRst),
        .extReq(extResetReq),
        .wdogReq(watchdogReq),
        .bodReq(bodReset),
        .chipReset(chipReset)
    );

    assign s_axi_awready = ~q.awHave & ~q.bValid;
    assign s_axi_wready = ~q.wHave & ~q.bValid;
    assign s_axi_bvalid = q.bValid;
    assign s_axi_bresp = q.bResp;
    assign s_axi_arready = ~q.rValid;
    assign s_axi_rvalid = q.rValid;
    assign s_axi_rdata = q.rData;
    assign s_axi_rresp = q.rResp;
    assign nvmCfgReq = q.nvmReq;
    assign nvmCfgAddr = q.nvmAddr;
    assign restartAddr = RESTART_ADDR;
    assign brownoutDetectOff = q.aux.brownoutDisable;
    assign lowPowerNvm = q.aux.lowPowerNvm;
    assign irq = |(q.stat & q.mask);

    sequence s_soft_write;
        ce && doWrite && q.wStrb0 && wSel == REG_AUX && q.wData[BIT_SOFT_RESET_BIT];
    endsequence
    sequence s_reset_seen;
        ##2 chipReset ##1 (q.aux == '0);
    endsequence
    property p_soft_reset;
        @(posedge clk) disable iff (sys_rst || !ce)
        s_soft_write |-> s_reset_seen;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missing");

    property p_zero_bits;
        @(posedge clk) disable iff (sys_rst)
        ce && s_axi_arvalid && s_axi_arready && rSel == REG_AUX
        |=> s_axi_rdata[BIT_ZERO] == 1'b0 && s_axi_rdata[BIT_SOFT_RESET_BIT] == 1'b0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("bit two reads one");

    property p_keypad_set;
        @(posedge clk) disable iff (sys_rst || chipReset)
        ce && keypadEvent |=> q.aux.keypadFlag && q.stat[IRQ_KEYPAD];
    endproperty
    a_keypad_set: assert property (p_keypad_set) else $error("keypad flag lost");

    property p_keypad_sticky;
        @(posedge clk) disable iff (sys_rst || chipReset)
        q.aux.keypadFlag && !$past(doWrite) ##0 !doWrite |=> q.aux.keypadFlag;
    endproperty
    a_keypad_sticky: assert property (p_keypad_sticky) else $error("keypad flag dropped");

    property p_lpnvm_sw;
        @(posedge clk) disable iff (sys_rst)
        $rose(lowPowerNvm) |-> $past(doWrite) && $past(wSel) == REG_AUX;
    endproperty
    a_lpnvm_sw: assert property (p_lpnvm_sw) else $error("low power bit set by hardware");

    property p_bod_irq;
        @(posedge clk) disable iff (sys_rst || chipReset)
        ce && brownoutEvent && q.aux.brownoutIrqSel && !q.aux.brownoutDisable
        |=> q.stat[IRQ_BROWNOUT] && !chipReset;
    endproperty
    a_bod_irq: assert property (p_bod_irq) else $error("brownout not rerouted");

    property p_bod_off;
        @(posedge clk) disable iff (sys_rst || chipReset)
        ce && doWrite && q.wStrb0 && wSel == REG_AUX
        |=> brownoutDetectOff == $past(q.wData[BIT_BOD]);
    endproperty
    a_bod_off: assert property (p_bod_off) else $error("brownout disable not applied");

    property p_toggle_only;
        @(posedge clk) disable iff (sys_rst || chipReset)
        ce && doWrite && q.wStrb0 && wSel == REG_AUX
        && q.wData[7:0] == auxRead + 8'h01
        |=> pack_aux(q.aux) == ($past(auxRead) ^ 8'h01);
    endproperty
    a_toggle_only: assert property (p_toggle_only) else $error("increment altered more");

    property p_nvm_ptr;
        @(posedge clk) disable iff (sys_rst || chipReset)
        ce && ptrOp.dataMove |=> nvmCfgReq && nvmCfgAddr == $past(selPointer);
    endproperty
    a_nvm_ptr: assert property (p_nvm_ptr) else $error("data move address wrong");
endmodule
`default_nettype wire

// ---- test/acdp_aux_control_test.sv ----
// Self-checking bench for the auxiliary control register block.
`timescale 1ns/1ps
`default_nettype none
module acdp_aux_control_test;
    import acdp_pkg::*;
    localparam int HOLD = 2;
    localparam logic [11:0] A_AUX = {AUX_IDX[9:0], 2'b00};
    localparam logic [11:0] A_STAT = {STAT_IDX[9:0], 2'b00};
    localparam logic [11:0] A_MASK = {MASK_IDX[9:0], 2'b00};
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic ce = 1'b1;
    logic [11:0] awAddr = '0;
    logic [11:0] arAddr = '0;
    logic [31:0] wData = '0;
    logic awValid = 1'b0;
    logic wValid = 1'b0;
    logic bReady = 1'b0;
    logic arValid = 1'b0;
    logic rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    acdp_ptr_op_s ptrOp = '0;
    logic [3:0] ev = '0;
    logic [15:0] selPointer, nvmCfgAddr, restartAddr;
    logic nvmCfgReq, chipReset, boOff, lpNvm, irq;
    int errCount = 0;
    int nCompared = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    acdp_aux_control #(.RST_HOLD(HOLD)) DUT (
        .clk(clk), .sys_rst(sysRst), .ce(ce),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .ptrOp(ptrOp), .selPointer(selPointer),
        .nvmCfgReq(nvmCfgReq), .nvmCfgAddr(nvmCfgAddr),
        .keypadEvent(ev[0]), .brownoutEvent(ev[1]),
        .extResetReq(ev[2]), .watchdogReq(ev[3]),
        .chipReset(chipReset), .restartAddr(restartAddr),
        .brownoutDetectOff(boOff), .lowPowerNvm(lpNvm), .irq(irq)
    );

    task automatic complete_run;
        $display("compared %0d mismatched %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic hang(input string nm);
        errCount++;
        $display("MISMATCH %s expected answer seen timeout", nm);
        complete_run();
    endtask

    // Address and data go out together; each is dropped once taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awValid && awReady === 1'b1) awValid <= 1'b0;
            if (wValid && wReady === 1'b1) wValid <= 1'b0;
            if (bValid === 1'b1) begin
                r = bResp;
                bReady <= 1'b0;
                break;
            end
        end
        if (n == 50) hang("write response");
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arValid && arReady === 1'b1) arValid <= 1'b0;
            if (rValid === 1'b1) begin
                d = rData;
                r = rResp;
                rReady <= 1'b0;
                break;
            end
        end
        if (n == 50) hang("read response");
    endtask

    task automatic wok(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", RESP_OKAY, r);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk("rdata", e, d);
        chk("rresp", er, r);
    endtask

    // One decoder operation; outputs are looked at once the edge lands.
    task automatic pop(input acdp_ptr_op_s o);
        @(posedge clk);
        ptrOp <= o;
        @(posedge clk);
        ptrOp <= '0;
        #1;
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 4'(1 << k);
        @(posedge clk);
        ev <= '0;
    endtask

    task automatic rstcnt(output int c);
        c = 0;
        repeat (12) begin
            @(posedge clk);
            if (chipReset === 1'b1) c++;
        end
    endtask

    task automatic t_reset;
        logic [1:0] r;
        chk("chipReset", 0, 32'(chipReset));
        chk("restartAddr", 0, 32'(restartAddr));
        chk("lowPowerNvm", 0, 32'(lpNvm));
        rchk(A_AUX, 0, RESP_OKAY);
        rchk(A_STAT, 0, RESP_OKAY);
        rchk(A_MASK, 0, RESP_OKAY);
        rchk(12'h100, 0, RESP_SLVERR);
        rchk(12'h289, 0, RESP_SLVERR);
        wr(12'h100, 32'h0000_0001, r);
        chk("bresp", RESP_SLVERR, r);
        $display("test reset done");
    endtask

    task automatic t_bits;
        logic [31:0] d;
        logic [1:0] r;
        wok(A_AUX, 32'h0000_0074);
        rchk(A_AUX, 32'h0000_0070, RESP_OKAY);
        chk("brownoutOff", 1, 32'(boOff));
        chk("lowPowerNvm", 1, 32'(lpNvm));
        rd(A_AUX, d, r);
        // The value read was 0x70, so the sum leaves bit one clear.
        wok(A_AUX, d + 32'h0000_0001);
        rchk(A_AUX, 32'h0000_0071, RESP_OKAY);
        wok(A_AUX, 0);
        $display("test bits done");
    endtask

    task automatic t_ptr;
        pop({5'b10000, 16'h1234});
        chk("selPointer", 16'h1234, 32'(selPointer));
        wok(A_AUX, 32'h0000_0001);
        chk("selPointer", 0, 32'(selPointer));
        pop({5'b10000, 16'hABCD});
        pop({5'b01000, 16'h0000});
        chk("selPointer", 16'hABCE, 32'(selPointer));
        pop({5'b00010, 16'h0055});
        chk("selPointer", 16'hAB55, 32'(selPointer));
        pop({5'b00100, 16'h0066});
        chk("selPointer", 16'h6655, 32'(selPointer));
        pop({5'b00001, 16'h0000});
        chk("nvmCfgReq", 1, 32'(nvmCfgReq));
        chk("nvmCfgAddr", 16'h6655, 32'(nvmCfgAddr));
        wok(A_AUX, 0);
        chk("selPointer", 16'h1234, 32'(selPointer));
        pop({5'b01000, 16'h0000});
        wok(A_AUX, 32'h0000_0001);
        chk("selPointer", 16'h6655, 32'(selPointer));
        wok(A_AUX, 0);
        chk("selPointer", 16'h1235, 32'(selPointer));
        $display("test pointers done");
    endtask

    task automatic t_keypad;
        pulse(0);
        rchk(A_AUX, 32'h0000_0080, RESP_OKAY);
        rchk(A_STAT, 32'h0000_0001, RESP_OKAY);
        chk("irq", 0, 32'(irq));
        wok(A_MASK, 32'h0000_0001);
        chk("irq", 1, 32'(irq));
        wok(A_AUX, 32'h0000_0080);
        rchk(A_AUX, 32'h0000_0080, RESP_OKAY);
        wok(A_AUX, 0);
        rchk(A_AUX, 0, RESP_OKAY);
        wok(A_STAT, 32'h0000_0001);
        chk("irq", 0, 32'(irq));
        chk("lowPowerNvm", 0, 32'(lpNvm));
        $display("test keypad done");
    endtask

    task automatic t_brownout;
        int c;
        wok(A_AUX, 32'h0000_0020);
        wok(A_MASK, 32'h0000_0002);
        pulse(1);
        rstcnt(c);
        chk("reset cycles", 0, 32'(c));
        rchk(A_STAT, 32'h0000_0002, RESP_OKAY);
        chk("irq", 1, 32'(irq));
        wok(A_STAT, 32'h0000_0002);
        wok(A_AUX, 32'h0000_0060);
        pulse(1);
        rstcnt(c);
        chk("reset cycles", 0, 32'(c));
        rchk(A_STAT, 0, RESP_OKAY);
        wok(A_AUX, 0);
        pulse(1);
        rstcnt(c);
        chk("reset seen", 1, 32'(c > 0));
        rchk(A_MASK, 0, RESP_OKAY);
        $display("test brownout done");
    endtask

    task automatic t_soft;
        int c;
        wok(A_AUX, 32'h0000_0001);
        pop({5'b10000, 16'h4321});
        wok(A_MASK, 32'h0000_0003);
        wok(A_AUX, 32'h0000_0009);
        rstcnt(c);
        chk("reset seen", 1, 32'(c > 0));
        rchk(A_AUX, 0, RESP_OKAY);
        rchk(A_MASK, 0, RESP_OKAY);
        chk("selPointer", 0, 32'(selPointer));
        chk("restartAddr", 0, 32'(restartAddr));
        $display("test soft reset done");
    endtask

    task automatic t_ext;
        int c;
        for (int k = 2; k < 4; k++) begin
            wok(A_MASK, 32'h0000_0003);
            wok(A_AUX, 32'h0000_0011);
            pulse(k);
            rstcnt(c);
            chk("reset cycles", 32'(HOLD), 32'(c));
            rchk(A_AUX, 0, RESP_OKAY);
            rchk(A_MASK, 0, RESP_OKAY);
        end
        $display("test external reset done");
    endtask

    // A keypad event while the enable is low must leave no trace.
    task automatic t_ce;
        @(posedge clk);
        ce <= 1'b0;
        pulse(0);
        @(posedge clk);
        ce <= 1'b1;
        rchk(A_STAT, 0, RESP_OKAY);
        rchk(A_AUX, 0, RESP_OKAY);
        $display("test clock enable done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        t_reset();
        t_bits();
        t_ptr();
        t_keypad();
        t_brownout();
        t_soft();
        t_ext();
        t_ce();
        complete_run();
    end
endmodule
`default_nettype wire
